// *** rtl/cdu_regs.svh ***
// Purpose: Register indices, field positions, reset values for the debug UART status block
// Assumes: Register byte address is four times the index
// Notes:   Definitions only
`ifndef CDU_REGS_SVH
`define CDU_REGS_SVH
`define CDU_IDX_PORT_STATE 12'h780
`define CDU_IDX_CMD_ERR    12'h781
`define CDU_IDX_DBG_CTRL   12'h78E
`define CDU_IDX_ERR_CLEAR  12'h78F
`define CDU_PORT_RST_BASE  6'h33
`define CDU_PORT_RST_STACK 6'h3F
`define CDU_CMD_ERR_RST    6'h00
`define CDU_DBG_CTRL_RST   8'hF4
`define CDU_BIT_SERIAL_DRV 5
`define CDU_BIT_DAISY_DRV  4
`define CDU_ERR_INIT       5
`define CDU_ERR_TXDIS      4
`define CDU_ERR_SOF        3
`define CDU_ERR_BYTE       2
`define CDU_ERR_UNEXP      1
`define CDU_ERR_CRC        0
`define CDU_CTL_DAISY_OVR  0
`define CDU_CTL_SERIAL_OVR 1
`define CDU_CTL_TX_EN      2
`define CDU_CTL_MIRROR     3
`define CDU_INIT_TYPE_BIT  7
`define CDU_INIT_RSVD_MASK 8'h08
`endif

// *** rtl/cdu_pkg.sv ***
// Purpose: Shared types of the debug UART status block
// Assumes: Constants live in cdu_regs.svh
// Notes:   Types only
package cdu_pkg;
    typedef enum logic [1:0] {
        CDU_WAIT_INIT = 2'b00,
        CDU_IN_FRAME  = 2'b01,
        CDU_DISCARD   = 2'b10
    } cdu_rx_state_t;
endpackage : cdu_pkg

// *** rtl/cdu_reg_if.sv ***
// Purpose: Register access strobes between bus slave and register file
// Assumes: One clock
// Notes:   Strobes last one cycle
interface cdu_reg_if;
    logic [11:0] idx;
    logic        rdStb;
    logic        wrStb;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rdOk;
    logic        wrOk;
    modport bus  (output idx, output rdStb, output wrStb, output wdata,
                  input rdata, input rdOk, input wrOk);
    modport regs (input idx, input rdStb, input wrStb, input wdata,
                  output rdata, output rdOk, output wrOk);
endinterface : cdu_reg_if

// *** rtl/cdu_apb_slave.sv ***
// Purpose: APB slave, zero wait states
// Assumes: Word aligned registers, index is paddr over four
// Notes:   Read data captured in setup so prdata comes from a flop
module cdu_apb_slave #(
    parameter int AW = 14
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    cdu_reg_if.bus             regs
);
    logic aligned;
    logic access;
    assign aligned     = (paddr[1:0] == 2'h0);
    assign access      = psel && penable;
    assign regs.idx    = 12'(paddr[AW-1:2]);
    assign regs.wdata  = pwdata[7:0];
    assign regs.rdStb  = access && !pwrite && aligned && regs.rdOk;
    assign regs.wrStb  = access && pwrite && aligned && regs.wrOk;
    assign pready      = 1'b1;
    // Unmapped, misaligned or read-only write answers with an error
    assign pslverr     = access && !(aligned && (pwrite ? regs.wrOk : regs.rdOk));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= (aligned && regs.rdOk) ? {24'h0, regs.rdata} : 32'h0;
        end
    end
endmodule : cdu_apb_slave

// *** rtl/cdu_sticky_bank.sv ***
// Purpose: Sticky flag bank with per-bit clear
// Assumes: Set and clear are one-cycle pulses
// Notes:   Set beats clear so a coincident event survives
module cdu_sticky_bank #(
    parameter int W = 6
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] setPulse,
    input  wire logic [W-1:0] clrPulse,
    output logic      [W-1:0] flags
);
    for (genvar i = 0; i < W; i++) begin : g_flag
        always_ff @(posedge core_clk) begin
            if (rst) begin
                flags[i] <= 1'b0;
            end else if (setPulse[i]) begin
                flags[i] <= 1'b1;
            end else if (clrPulse[i]) begin
                flags[i] <= 1'b0;
            end
        end
    end
endmodule : cdu_sticky_bank

// *** rtl/cdu_top.sv ***
// Purpose: Debug port state and serial command frame error status
// Assumes: Byte and frame events come from the UART receiver on core_clk
// Notes:   Frame counters live outside; this block only pulses them
`include "cdu_regs.svh"
module cdu_top #(
    parameter int AW = 14
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          isStackDevice,
    input  wire logic          multidropOn,
    input  wire logic          devSerialTxEn,
    input  wire logic [3:0]    devDaisyEn,
    input  wire logic          rxByteValid,
    input  wire logic [7:0]    rxByte,
    input  wire logic          rxStopErr,
    input  wire logic          lineClear,
    input  wire logic          frameDone,
    input  wire logic          crcFail,
    input  wire logic          cmdIsRead,
    input  wire logic          cmdIsStackOrBcast,
    output logic               serialTxEn,
    output logic               serialMirrorEn,
    output logic      [3:0]    daisyEn,
    output logic               validFrameInc,
    output logic               discardFrameInc
);
    cdu_reg_if regBus ();

    cdu_pkg::cdu_rx_state_t state_q;
    cdu_pkg::cdu_rx_state_t state_d;
    logic [7:0] ctrl_q;
    logic [5:0] portState_q;
    logic [5:0] errFlags;
    logic [5:0] errSet;
    logic [5:0] errClr;
    logic       serialTxEn_q;
    logic       serialMirror_q;
    logic       validInc_q;
    logic       discardInc_q;
    logic       daisyOvr;
    logic       serialOvr;
    logic       initBad;
    logic       byteBad;
    logic       sofErr;
    logic       frameEnd;
    logic       crcErr;
    logic       txdisErr;
    logic       unexpErr;
    logic       discardNow;

    cdu_apb_slave #(.AW(AW)) u_apb (
        .core_clk (core_clk),
        .rst      (rst),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .regs     (regBus.bus)
    );

    // Debug control register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= `CDU_DBG_CTRL_RST;
        end else if (regBus.wrStb && regBus.idx == `CDU_IDX_DBG_CTRL) begin
            ctrl_q <= regBus.wdata;
        end
    end

    assign daisyOvr  = ctrl_q[`CDU_CTL_DAISY_OVR];
    assign serialOvr = ctrl_q[`CDU_CTL_SERIAL_OVR];

    // Live port state; reset value depends on base or stack role
    always_ff @(posedge core_clk) begin
        if (rst) begin
            portState_q <= isStackDevice ? `CDU_PORT_RST_STACK : `CDU_PORT_RST_BASE;
        end else begin
            portState_q[3:0] <= daisyOvr ? ctrl_q[7:4] : devDaisyEn;
            portState_q[`CDU_BIT_DAISY_DRV]  <= !daisyOvr;
            portState_q[`CDU_BIT_SERIAL_DRV] <= !serialOvr;
        end
    end

    // Serial transmitter control
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serialTxEn_q   <= 1'b1;
            serialMirror_q <= 1'b0;
        end else begin
            serialTxEn_q   <= serialOvr ? ctrl_q[`CDU_CTL_TX_EN] : devSerialTxEn;
            serialMirror_q <= serialOvr && ctrl_q[`CDU_CTL_MIRROR];
        end
    end

    assign daisyEn        = portState_q[3:0];
    assign serialTxEn     = serialTxEn_q;
    assign serialMirrorEn = serialMirror_q;

    // Error detection; line clear outranks any byte in the same cycle
    assign initBad  = rxByteValid && !lineClear && state_q == cdu_pkg::CDU_WAIT_INIT
                      && (rxStopErr || !rxByte[`CDU_INIT_TYPE_BIT]
                          || |(rxByte & `CDU_INIT_RSVD_MASK));
    assign byteBad  = rxByteValid && rxStopErr && !lineClear
                      && state_q == cdu_pkg::CDU_IN_FRAME;
    assign sofErr   = lineClear && state_q == cdu_pkg::CDU_IN_FRAME;
    assign frameEnd = frameDone && !lineClear && !byteBad
                      && state_q == cdu_pkg::CDU_IN_FRAME;
    assign crcErr   = frameEnd && crcFail;
    // A frame already failing CRC is discarded, so nothing else is reported
    assign txdisErr = frameEnd && !crcFail && cmdIsRead && !serialTxEn_q;
    assign unexpErr = frameEnd && !crcFail && isStackDevice && !multidropOn
                      && cmdIsStackOrBcast;
    assign discardNow = crcErr || txdisErr || unexpErr;

    always_comb begin
        state_d = state_q;
        if (lineClear) begin
            state_d = cdu_pkg::CDU_WAIT_INIT;
        end else begin
            case (state_q)
                cdu_pkg::CDU_WAIT_INIT: begin
                    if (rxByteValid) begin
                        state_d = initBad ? cdu_pkg::CDU_DISCARD : cdu_pkg::CDU_IN_FRAME;
                    end
                end
                cdu_pkg::CDU_IN_FRAME: begin
                    if (byteBad) begin
                        state_d = cdu_pkg::CDU_DISCARD;
                    end else if (frameEnd) begin
                        state_d = cdu_pkg::CDU_WAIT_INIT;
                    end
                end
                cdu_pkg::CDU_DISCARD: begin
                    state_d = cdu_pkg::CDU_DISCARD;
                end
                default: begin
                    state_d = cdu_pkg::CDU_WAIT_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= cdu_pkg::CDU_WAIT_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Counter pulses; an ignored frame never reaches frameEnd
    always_ff @(posedge core_clk) begin
        if (rst) begin
            validInc_q   <= 1'b0;
            discardInc_q <= 1'b0;
        end else begin
            validInc_q   <= frameEnd && !discardNow;
            discardInc_q <= discardNow;
        end
    end

    assign validFrameInc   = validInc_q;
    assign discardFrameInc = discardInc_q;

    assign errSet = {initBad, txdisErr, sofErr, byteBad, unexpErr, crcErr};
    // Bits written one to the clear register drop, unless set again that cycle
    assign errClr = (regBus.wrStb && regBus.idx == `CDU_IDX_ERR_CLEAR)
                    ? regBus.wdata[5:0] : 6'h00;

    cdu_sticky_bank #(.W(6)) u_flags (
        .core_clk (core_clk),
        .rst      (rst),
        .setPulse (errSet),
        .clrPulse (errClr),
        .flags    (errFlags)
    );

    // Read decode
    always_comb begin
        regBus.rdata = 8'h00;
        regBus.rdOk  = 1'b1;
        regBus.wrOk  = 1'b0;
        case (regBus.idx)
            `CDU_IDX_PORT_STATE: regBus.rdata = {2'h0, portState_q};
            `CDU_IDX_CMD_ERR:    regBus.rdata = {2'h0, errFlags};
            `CDU_IDX_DBG_CTRL: begin
                regBus.rdata = ctrl_q;
                regBus.wrOk  = 1'b1;
            end
            `CDU_IDX_ERR_CLEAR:  regBus.wrOk  = 1'b1;
            default:             regBus.rdOk  = 1'b0;
        endcase
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_bad_byte;
        state_q == cdu_pkg::CDU_IN_FRAME && rxByteValid && rxStopErr && !lineClear;
    endsequence

    sequence s_ignored_bytes;
        (state_q == cdu_pkg::CDU_DISCARD && !lineClear)[*3];
    endsequence

    property p_daisy_follow;
        daisyOvr |=> portState_q[3:0] == $past(ctrl_q[7:4]);
    endproperty
    a_daisy_follow: assert property (p_daisy_follow)
        else $error("daisy state does not follow debug enables");

    property p_daisy_device;
        !daisyOvr |=> portState_q[3:0] == $past(devDaisyEn) && portState_q[4];
    endproperty
    a_daisy_device: assert property (p_daisy_device)
        else $error("daisy ports not under device control");

    property p_init_err;
        state_q == cdu_pkg::CDU_WAIT_INIT && rxByteValid && !lineClear
            && !rxByte[`CDU_INIT_TYPE_BIT]
        |=> errFlags[`CDU_ERR_INIT] && state_q == cdu_pkg::CDU_DISCARD;
    endproperty
    a_init_err: assert property (p_init_err)
        else $error("bad init byte not flagged");

    property p_ignore_until_clear;
        s_bad_byte ##1 s_ignored_bytes |=> state_q == cdu_pkg::CDU_DISCARD;
    endproperty
    a_ignore_until_clear: assert property (p_ignore_until_clear)
        else $error("discard left without line clear");

    property p_no_count;
        state_q == cdu_pkg::CDU_DISCARD |=> !validFrameInc && !discardFrameInc;
    endproperty
    a_no_count: assert property (p_no_count)
        else $error("ignored frame counted");

    property p_txdis;
        frameEnd && !crcFail && cmdIsRead && !serialTxEn
        |=> errFlags[`CDU_ERR_TXDIS] && discardFrameInc;
    endproperty
    a_txdis: assert property (p_txdis)
        else $error("read with transmitter off not flagged");

    property p_sof;
        lineClear && state_q == cdu_pkg::CDU_IN_FRAME
        |=> errFlags[`CDU_ERR_SOF] && state_q == cdu_pkg::CDU_WAIT_INIT;
    endproperty
    a_sof: assert property (p_sof)
        else $error("early line clear not flagged");

    property p_byte_err;
        s_bad_byte |=> errFlags[`CDU_ERR_BYTE] ##0 state_q == cdu_pkg::CDU_DISCARD;
    endproperty
    a_byte_err: assert property (p_byte_err)
        else $error("byte error not flagged");

    property p_unexp;
        frameEnd && !crcFail && isStackDevice && !multidropOn && cmdIsStackOrBcast
        |=> errFlags[`CDU_ERR_UNEXP];
    endproperty
    a_unexp: assert property (p_unexp)
        else $error("unexpected command not flagged");

    property p_no_unexp;
        multidropOn && !errFlags[`CDU_ERR_UNEXP] |=> !errFlags[`CDU_ERR_UNEXP];
    endproperty
    a_no_unexp: assert property (p_no_unexp)
        else $error("unexpected flag set under multidrop");

    property p_crc;
        frameEnd && crcFail
        |=> errFlags[`CDU_ERR_CRC] && discardFrameInc && !validFrameInc;
    endproperty
    a_crc: assert property (p_crc)
        else $error("crc failure not flagged as discard");

    property p_clear;
        errClr[`CDU_ERR_CRC] && !errSet[`CDU_ERR_CRC] |=> !errFlags[`CDU_ERR_CRC];
    endproperty
    a_clear: assert property (p_clear)
        else $error("flag not cleared");

    property p_serial_src;
        !serialOvr |=> serialTxEn == $past(devSerialTxEn) && !serialMirrorEn
                       ##0 portState_q[`CDU_BIT_SERIAL_DRV];
    endproperty
    a_serial_src: assert property (p_serial_src)
        else $error("serial override not ignored");

    property p_serial_ovr;
        serialOvr |=> serialTxEn == $past(ctrl_q[`CDU_CTL_TX_EN])
                      && serialMirrorEn == $past(ctrl_q[`CDU_CTL_MIRROR])
                      ##0 !portState_q[`CDU_BIT_SERIAL_DRV];
    endproperty
    a_serial_ovr: assert property (p_serial_ovr)
        else $error("serial override settings not applied");

    property p_init_good;
        state_q == cdu_pkg::CDU_WAIT_INIT && rxByteValid && !lineClear && !rxStopErr
            && rxByte[`CDU_INIT_TYPE_BIT] && (rxByte & `CDU_INIT_RSVD_MASK) == 8'h00
        |=> state_q == cdu_pkg::CDU_IN_FRAME;
    endproperty
    a_init_good: assert property (p_init_good)
        else $error("good init byte did not open a frame");

    property p_init_stop;
        state_q == cdu_pkg::CDU_WAIT_INIT && rxByteValid && !lineClear && rxStopErr
        |=> errFlags[`CDU_ERR_INIT] && state_q == cdu_pkg::CDU_DISCARD;
    endproperty
    a_init_stop: assert property (p_init_stop)
        else $error("init byte stop fault not flagged");

    property p_discard_exit;
        state_q == cdu_pkg::CDU_DISCARD && lineClear |=> state_q == cdu_pkg::CDU_WAIT_INIT;
    endproperty
    a_discard_exit: assert property (p_discard_exit)
        else $error("line clear did not end discard");

    // Ignored frames must raise no error class at all
    property p_discard_quiet;
        state_q == cdu_pkg::CDU_DISCARD |-> errSet == 6'h00;
    endproperty
    a_discard_quiet: assert property (p_discard_quiet)
        else $error("error detected in ignored frame");

    property p_valid_count;
        frameEnd && !crcFail && !(cmdIsRead && !serialTxEn)
            && !(isStackDevice && !multidropOn && cmdIsStackOrBcast)
        |=> validFrameInc && !discardFrameInc;
    endproperty
    a_valid_count: assert property (p_valid_count)
        else $error("clean frame not counted valid");

    property p_set_wins;
        errSet != 6'h00 |=> (errFlags & $past(errSet)) == $past(errSet);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("detected error did not set its flag");

    property p_state_read;
        psel && !penable && !pwrite && paddr[1:0] == 2'h0
            && regBus.idx == `CDU_IDX_PORT_STATE
        |=> prdata == {26'h0, $past(portState_q)};
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("port state read data wrong");
endmodule : cdu_top

// *** tb/cdu_host_model.sv ***
// Purpose: Host side model feeding serial command frame events
// Assumes: Every event is a one-cycle strobe launched after a rising edge
// Notes:   Off-strobe data shows the inverse of the last value, never stale data
module cdu_host_model (
    input  wire logic       core_clk,
    output logic            rxByteValid,
    output logic      [7:0] rxByte,
    output logic            rxStopErr,
    output logic            lineClear,
    output logic            frameDone,
    output logic      [2:0] endInfo
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle cycles after each event; raised to act as a slow host
    int gap = 0;
    initial begin
        rxByteValid = 1'h0;
        rxByte      = 8'hA5;
        rxStopErr   = 1'h0;
        lineClear   = 1'h0;
        frameDone   = 1'h0;
        endInfo     = 3'h5;
    end
    task automatic idle();
        repeat (gap) @(posedge core_clk);
    endtask : idle
    task automatic send_byte(input logic [7:0] b, input logic se);
        @(posedge core_clk);
        rxByteValid <= 1'h1;
        rxByte      <= b;
        rxStopErr   <= se;
        @(posedge core_clk);
        rxByteValid <= 1'h0;
        rxByte      <= ~b;
        rxStopErr   <= ~se;
        idle();
    endtask : send_byte
    task automatic clear_line();
        @(posedge core_clk);
        lineClear <= 1'h1;
        @(posedge core_clk);
        lineClear <= 1'h0;
        idle();
    endtask : clear_line
    // Qualifiers {crc fail, read, stack or broadcast} only valid with the strobe
    task automatic end_frame(input logic [2:0] k);
        @(posedge core_clk);
        frameDone <= 1'h1;
        endInfo   <= k;
        @(posedge core_clk);
        frameDone <= 1'h0;
        endInfo   <= ~k;
        idle();
    endtask : end_frame
endmodule : cdu_host_model

// *** tb/tb_comm_debug_uart_cmd_errors.sv ***
// Purpose: Self-checking bench for port state and command frame error status
// Assumes: Zero wait APB slave; byte address is index times four
// Notes:   Frame counter pulses are tallied here and compared per frame
`include "cdu_regs.svh"
module tb_comm_debug_uart_cmd_errors;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [13:0] A_STATE = {`CDU_IDX_PORT_STATE, 2'h0};
    localparam logic [13:0] A_ERR   = {`CDU_IDX_CMD_ERR, 2'h0};
    localparam logic [13:0] A_CTRL  = {`CDU_IDX_DBG_CTRL, 2'h0};
    localparam logic [13:0] A_CLR   = {`CDU_IDX_ERR_CLEAR, 2'h0};
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        isStackDevice, multidropOn, devSerialTxEn, serialTxEn, serialMirrorEn;
    logic [3:0]  devDaisyEn, daisyEn;
    logic        rxByteValid, rxStopErr, lineClear, frameDone, validFrameInc, discardFrameInc;
    logic [7:0]  rxByte;
    logic [2:0]  endInfo;
    int          mismatches = 0, nTests = 0, nValid = 0, nDisc = 0, cyc = 0;

    cdu_top #(.AW(14)) u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .isStackDevice(isStackDevice), .multidropOn(multidropOn),
        .devSerialTxEn(devSerialTxEn), .devDaisyEn(devDaisyEn), .rxByteValid(rxByteValid),
        .rxByte(rxByte), .rxStopErr(rxStopErr), .lineClear(lineClear), .frameDone(frameDone),
        .crcFail(endInfo[2]), .cmdIsRead(endInfo[1]), .cmdIsStackOrBcast(endInfo[0]),
        .serialTxEn(serialTxEn), .serialMirrorEn(serialMirrorEn), .daisyEn(daisyEn),
        .validFrameInc(validFrameInc), .discardFrameInc(discardFrameInc));
    cdu_host_model u_host (.core_clk(core_clk), .rxByteValid(rxByteValid), .rxByte(rxByte),
        .rxStopErr(rxStopErr), .lineClear(lineClear), .frameDone(frameDone),
        .endInfo(endInfo));

    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // Ceiling well above the expected few hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (validFrameInc === 1'h1) nValid++;
        if (discardFrameInc === 1'h1) nDisc++;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; waits for pready, takes rd and err at that edge
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask : settle
    // f = {init stop fault, second byte stop fault, line clear before end}
    task automatic frame(input logic [7:0] ini, input logic [2:0] f, input logic [2:0] k,
                         input logic [5:0] ef, input int ev, input int ed);
        int v0;
        int d0;
        u_host.clear_line();
        apb(1'h1, A_CLR, 32'h0000003F);
        v0 = nValid;
        d0 = nDisc;
        u_host.send_byte(ini, f[2]);
        u_host.send_byte(8'h5A, f[1]);
        if (f[0]) u_host.clear_line();
        u_host.end_frame(k);
        settle();
        apb(1'h0, A_ERR, 32'h0);
        chk("errFlags", {26'h0, ef}, rd);
        chk("validInc", ev, nValid - v0);
        chk("discardInc", ed, nDisc - d0);
    endtask : frame

    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 14'h0;
        pwdata = 32'h0;
        isStackDevice = 1'h0;
        multidropOn = 1'h0;
        devSerialTxEn = 1'h1;
        devDaisyEn = 4'h3;
        repeat (12) @(posedge core_clk);
        rst <= 1'h0;
        apb(1'h0, A_STATE, 32'h0);
        chk("stateBase", 32'h33, rd);
        apb(1'h0, A_ERR, 32'h0);
        chk("errReset", 32'h0, rd);
        devDaisyEn <= 4'hA;
        settle();
        apb(1'h0, A_STATE, 32'h0);
        chk("stateLive", 32'h3A, rd);
        chk("daisyLive", 32'hA, {28'h0, daisyEn});
        apb(1'h1, A_CTRL, 32'h51);
        settle();
        chk("daisyOvr", 32'h5, {28'h0, daisyEn});
        apb(1'h0, A_STATE, 32'h0);
        chk("stateDaisyOvr", 32'h25, rd);
        // Serial override on, transmitter off, mirror on
        apb(1'h1, A_CTRL, 32'h0A);
        settle();
        chk("txOvr", 32'h0, {31'h0, serialTxEn});
        chk("mirrorOvr", 32'h1, {31'h0, serialMirrorEn});
        apb(1'h0, A_STATE, 32'h0);
        chk("stateSerialOvr", 32'h1A, rd);
        frame(8'h80, 3'h0, 3'h2, 6'h10, 0, 1);
        // Override off: debug mirror bit must have no effect
        apb(1'h1, A_CTRL, 32'h08);
        settle();
        chk("txDev", 32'h1, {31'h0, serialTxEn});
        chk("mirrorDev", 32'h0, {31'h0, serialMirrorEn});
        frame(8'h80, 3'h0, 3'h2, 6'h00, 1, 0);
        frame(8'h00, 3'h0, 3'h4, 6'h20, 0, 0);
        frame(8'h88, 3'h0, 3'h4, 6'h20, 0, 0);
        frame(8'h80, 3'h4, 3'h2, 6'h20, 0, 0);
        frame(8'h80, 3'h2, 3'h4, 6'h04, 0, 0);
        frame(8'h80, 3'h1, 3'h4, 6'h08, 0, 0);
        frame(8'h80, 3'h0, 3'h6, 6'h01, 0, 1);
        frame(8'h80, 3'h0, 3'h1, 6'h00, 1, 0);
        apb(1'h0, 14'h1E08, 32'h0);
        chk("unmappedErr", 32'h1, {31'h0, err});
        chk("unmappedData", 32'h0, rd);
        apb(1'h1, A_ERR, 32'hFF);
        chk("roWriteErr", 32'h1, {31'h0, err});
        // Stack role reset, slow host from here on
        rst <= 1'h1;
        isStackDevice <= 1'h1;
        devDaisyEn <= 4'hF;
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        apb(1'h0, A_STATE, 32'h0);
        chk("stateStack", 32'h3F, rd);
        u_host.gap = 2;
        frame(8'h80, 3'h0, 3'h1, 6'h02, 0, 1);
        multidropOn <= 1'h1;
        frame(8'h80, 3'h0, 3'h1, 6'h00, 1, 0);
        close_out();
    end
endmodule : tb_comm_debug_uart_cmd_errors
